// >>> trig_acq_pkg.sv
// Summary of operation
// (R1) Status bit 8 shows board ready: clock synthesiser and converters synchronised.
// (R2) Software polls ready after reset before setting run.
// (R3) Status bit 7 drops on lock loss, stays low until status read.
// (R4) Status bit 6 shows synthesiser bypass mode.
// (R5) Status bit 5 shows clock source, one for external reference.
// (R6) Status bit 4 is one when stored events reach buffer maximum.
// (R7) Status bit 3 is one when at least one event awaits readout.
// (R8) Status bit 2 shows acquisition running.
// (R9) Any write to software trigger location issues one software trigger.
// (R10) Software triggers accepted only while source mask bit 31 is set.
// (R11) External trigger input accepted only while source mask bit 30 set.
// (R12) Source mask bit n lets channel n raise a local trigger.
// (R13) Local trigger needs coincidence count of other enabled channels over threshold.
// (R14) Software keeps coincidence count below number of enabled channels.
// (R15) Output mask bit n lets channel n drive the trigger output.
// (R16) Output mask bits 30 and 31 forward external and software triggers.
// (R17) Post-trigger samples equal four times register value plus fixed delay.
// (R18) Fixed pipeline delay is a build constant.
// (R19) Panel data read returns line levels; write sets output lines.
// (R20) While stopped, every trigger from every source is ignored; code gates only acq_trigger_o with run, trigger output still forwards.
// (R21) Data written to software trigger location is ignored.
// (R22) Reserved bits read zero; writes to them have no effect.
package trig_acq_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] STATUS_ADDR = 16'h8104;
  localparam logic [15:0] SWTRIG_ADDR = 16'h8108;
  localparam logic [15:0] SRCMASK_ADDR = 16'h810c;
  localparam logic [15:0] OUTMASK_ADDR = 16'h8110;
  localparam logic [15:0] POST_ADDR = 16'h8114;
  localparam logic [15:0] PANEL_ADDR = 16'h8118;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int NUM_CH = 8;
  localparam int READY_BIT = 8;
  localparam int LOCK_BIT = 7;
  localparam int BYPASS_BIT = 6;
  localparam int CLKSRC_BIT = 5;
  localparam int FULL_BIT = 4;
  localparam int EVRDY_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int SW_EN_BIT = 31;
  localparam int EXT_EN_BIT = 30;
  localparam int COINC_LSB = 24;
  localparam logic [31:0] SRCMASK_WMASK = 32'hc70000ff;
  localparam logic [31:0] OUTMASK_WMASK = 32'hc00000ff;
  localparam logic [31:0] SRCMASK_RST = 32'h00000000;
  localparam logic [31:0] OUTMASK_RST = 32'h00000000;
  localparam logic [31:0] POST_RST = 32'h00000000;
  localparam logic [15:0] PANEL_RST = 16'h0000;
  localparam logic [33:0] FIXED_PIPELINE_DELAY = 34'h000000010;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : trig_acq_pkg

// >>> trigger_acquisition_status.sv
`timescale 1ns/1ps
module trigger_acquisition_status
  import trig_acq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Board state inputs from other clock domains
  input wire logic sync_ok_i,
  input wire logic pll_lock_i,
  input wire logic pll_bypass_i,
  input wire logic clk_ext_i,
  input wire logic buffer_full_i,
  input wire logic event_ready_i,
  input wire logic run_i,
  // Trigger sources
  input wire logic external_trigger_input_i,
  input wire logic [7:0] ch_over_thr_i,
  // Trigger outputs
  output logic acq_trigger_o,
  output logic trigger_output_pin_o,
  output logic [33:0] post_samples_o,
  // Panel LVDS lines
  input wire logic [15:0] panel_in_i,
  output logic [15:0] panel_out_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 16 + 8 + 8;
  // Lock line starts high so a reset alone never reads as a lock loss
  localparam logic [NSYNC-1:0] SYNC_RST = 32'h00000002;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] raw_in;
  assign raw_in = {panel_in_i, ch_over_thr_i, external_trigger_input_i, run_i, event_ready_i,
                   buffer_full_i, clk_ext_i, pll_bypass_i, pll_lock_i, sync_ok_i};

  // Two stages per line; only sync_b is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync_a[gi] <= SYNC_RST[gi];
          sync_b[gi] <= SYNC_RST[gi];
        end else if (clk_en_i) begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic s_ready, s_lock, s_bypass, s_ext, s_full, s_evrdy, s_run, s_external_trigger_input;
  logic [7:0] s_over;
  logic [15:0] s_panel;
  assign s_ready = sync_b[0];
  assign s_lock = sync_b[1];
  assign s_bypass = sync_b[2];
  assign s_ext = sync_b[3];
  assign s_full = sync_b[4];
  assign s_evrdy = sync_b[5];
  assign s_run = sync_b[6];
  assign s_external_trigger_input = sync_b[7];
  assign s_over = sync_b[15:8];
  assign s_panel = sync_b[31:16];

  // ****************************************
  // AHB-Lite address phase capture
  // ****************************************
  logic ph_valid;
  logic ph_write;
  logic [15:0] ph_addr;
  logic take;
  assign take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

  // Slave never stalls and always answers OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 16'h0000;
    end else if (clk_en_i) begin
      ph_valid <= take;
      ph_write <= hwrite_i;
      ph_addr <= haddr_i[15:0];
    end
  end

  logic wr_en, rd_en;
  assign wr_en = ph_valid && ph_write;
  assign rd_en = take && !hwrite_i;

  // ****************************************
  // Control registers
  // ****************************************
  logic [31:0] src_mask;
  logic [31:0] out_mask;
  logic [31:0] post_len;
  logic [15:0] panel_out;
  logic sw_trig;

  // Reserved bits are masked off on write so they always read zero
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_mask <= SRCMASK_RST;
      out_mask <= OUTMASK_RST;
      post_len <= POST_RST;
      panel_out <= PANEL_RST;
    end else if (clk_en_i && wr_en) begin
      case (ph_addr)
        SRCMASK_ADDR: src_mask <= hwdata_i & SRCMASK_WMASK; // R22
        OUTMASK_ADDR: out_mask <= hwdata_i & OUTMASK_WMASK; // R22
        POST_ADDR: post_len <= hwdata_i;
        PANEL_ADDR: panel_out <= hwdata_i[15:0]; // R19
        default: ;
      endcase
    end
  end
  assign panel_out_o = panel_out;

  // Software trigger pulse: the write itself matters, never its data
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sw_trig <= 1'b0;
    end else if (clk_en_i) begin
      sw_trig <= wr_en && (ph_addr == SWTRIG_ADDR); // R9 R21
    end
  end

  // ****************************************
  // Lock-loss sticky flag
  // ****************************************
  logic lock_flag;
  logic status_rd;
  assign status_rd = rd_en && (haddr_i[15:0] == STATUS_ADDR);

  // Loss wins over the restoring read so no loss is missed
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_flag <= 1'b1;
    end else if (clk_en_i) begin
      if (!s_lock) begin
        lock_flag <= 1'b0; // R3
      end else if (status_rd) begin
        lock_flag <= 1'b1; // R3
      end
    end
  end

  // ****************************************
  // Trigger logic
  // ****************************************
  logic [7:0] local_over;
  logic [3:0] over_cnt;
  logic [2:0] coinc;
  logic local_hit;
  logic next_acq, next_tout;
  logic acq_trig, tout;

  assign local_over = s_over & src_mask[NUM_CH-1:0]; // R12
  assign coinc = src_mask[COINC_LSB+2:COINC_LSB];

  always_comb begin
    over_cnt = 4'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      over_cnt = over_cnt + {3'h0, local_over[i]};
    end
  end

  // One triggering channel plus the coincidence level of others
  assign local_hit = (over_cnt != 4'h0) && ((over_cnt - 4'h1) >= {1'b0, coinc}); // R13

  always_comb begin
    next_acq = s_run && ((sw_trig && src_mask[SW_EN_BIT]) // R10 R20
                      || (s_external_trigger_input && src_mask[EXT_EN_BIT]) // R11
                      || local_hit);
    next_tout = |(s_over & out_mask[NUM_CH-1:0]) // R15
             || (s_external_trigger_input && out_mask[EXT_EN_BIT]) // R16
             || (sw_trig && out_mask[SW_EN_BIT]); // R16
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acq_trig <= 1'b0;
      tout <= 1'b0;
    end else if (clk_en_i) begin
      acq_trig <= next_acq;
      tout <= next_tout;
    end
  end
  assign acq_trigger_o = acq_trig;
  assign trigger_output_pin_o = tout;

  // Post-trigger sample count; the delay term is fixed per build
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      post_samples_o <= 34'h000000000;
    end else if (clk_en_i) begin
      post_samples_o <= {post_len, 2'b00} + FIXED_PIPELINE_DELAY; // R17 R18
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[READY_BIT] = s_ready; // R1
    status_word[LOCK_BIT] = lock_flag; // R3
    status_word[BYPASS_BIT] = s_bypass; // R4
    status_word[CLKSRC_BIT] = s_ext; // R5
    status_word[FULL_BIT] = s_full; // R6
    status_word[EVRDY_BIT] = s_evrdy; // R7
    status_word[RUN_BIT] = s_run; // R8
  end

  // Read data is registered at the address phase, unmapped reads return zero
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h00000000;
    end else if (clk_en_i && rd_en) begin
      case (haddr_i[15:0])
        STATUS_ADDR: hrdata_o <= status_word;
        SRCMASK_ADDR: hrdata_o <= src_mask;
        OUTMASK_ADDR: hrdata_o <= out_mask;
        POST_ADDR: hrdata_o <= post_len;
        PANEL_ADDR: hrdata_o <= {16'h0000, s_panel}; // R19
        default: hrdata_o <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_STOP_NO_TRIG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R20
    clk_en_i && !s_run |=> !acq_trig)
    else $error("trigger while stopped");
  AST_SW_TRIG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R9
    clk_en_i && wr_en && ph_addr == SWTRIG_ADDR |=> sw_trig)
    else $error("software trigger missing");
  AST_SW_GATE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R10
    clk_en_i && sw_trig && s_run && src_mask[SW_EN_BIT] |=> acq_trig)
    else $error("enabled software trigger lost");
  AST_EXT_GATE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R11
    clk_en_i && s_external_trigger_input && s_run && src_mask[EXT_EN_BIT] |=> acq_trig)
    else $error("enabled external trigger lost");
  AST_LOCK_LOW: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R3
    clk_en_i && !s_lock |=> !lock_flag)
    else $error("lock flag not cleared");
  AST_LOCK_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R3
    clk_en_i && !lock_flag && !status_rd |=> !lock_flag)
    else $error("lock flag restored without read");
  AST_OUT_EXT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R16
    clk_en_i && s_external_trigger_input && out_mask[EXT_EN_BIT] |=> tout)
    else $error("external trigger not forwarded");
  AST_RESERVED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R22
    (src_mask & ~SRCMASK_WMASK) == 32'h0 && (out_mask & ~OUTMASK_WMASK) == 32'h0)
    else $error("reserved bits set");
  AST_POST: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R17
    clk_en_i |=> post_samples_o == {$past(post_len), 2'b00} + FIXED_PIPELINE_DELAY)
    else $error("post sample count wrong");

  // The checks below watch the register side and the trigger paths one cycle on; the bus answer check looks at the same cycle.
  // They also sample the bus inputs haddr_i and hwdata_i, so a failure can point
  // at the bus master as well as at the logic here.
  // Each fires at most one cycle after its cause, matching the single flop stage.

  // A software trigger write leaves the source mask and post-trigger length unchanged
  AST_SW_DATA_IGNORED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R21
    clk_en_i && wr_en && ph_addr == SWTRIG_ADDR |=> $stable(src_mask) && $stable(post_len))
    else $error("software trigger data stored");

  // Software trigger forwarded to the trigger output when enabled
  AST_SW_OUT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R16
    clk_en_i && sw_trig && out_mask[SW_EN_BIT] |=> tout)
    else $error("software trigger not forwarded");

  // Enabled channel crossing drives the trigger output
  AST_CH_OUT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R15
    clk_en_i && (s_over & out_mask[NUM_CH-1:0]) != 8'h00 |=> tout)
    else $error("channel crossing not forwarded");

  // With no enabled source the trigger output stays low
  AST_QUIET_OUT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R15
    clk_en_i && (s_over & out_mask[NUM_CH-1:0]) == 8'h00 && !s_external_trigger_input && !sw_trig |=> !tout)
    else $error("spurious output trigger");

  // Coincidence met while running gives an acquisition trigger
  AST_LOCAL_HIT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R13
    clk_en_i && s_run && local_hit |=> acq_trig)
    else $error("local trigger lost");

  // Masked channels alone never trigger acquisition
  AST_LOCAL_MASKED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R12
    clk_en_i && local_over == 8'h00 && !sw_trig && !s_external_trigger_input |=> !acq_trig)
    else $error("trigger from masked channel");

  // A status read with lock present restores the flag
  AST_LOCK_RESTORE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R3
    clk_en_i && s_lock && status_rd |=> lock_flag)
    else $error("lock flag not restored");

  // Status read returns the status word of the address phase
  AST_STATUS_READ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R1
    clk_en_i && rd_en && haddr_i[15:0] == STATUS_ADDR |=> hrdata_o == $past(status_word))
    else $error("status read data wrong");

  // Source mask reads back as stored
  AST_SRC_READ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R22
    clk_en_i && rd_en && haddr_i[15:0] == SRCMASK_ADDR |=> hrdata_o == $past(src_mask))
    else $error("source mask read wrong");

  // Panel read returns the synchronised line levels
  AST_PANEL_READ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R19
    clk_en_i && rd_en && haddr_i[15:0] == PANEL_ADDR |=> hrdata_o == {16'h0000, $past(s_panel)})
    else $error("panel read wrong");

  // Panel write lands on the output lines
  AST_PANEL_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R19
    clk_en_i && wr_en && ph_addr == PANEL_ADDR |=> panel_out_o == $past(hwdata_i[15:0]))
    else $error("panel write lost");

  // Post-trigger value stored whole
  AST_POST_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R17
    clk_en_i && wr_en && ph_addr == POST_ADDR |=> post_len == $past(hwdata_i))
    else $error("post write lost");

  // Source mask keeps only its defined fields
  AST_SRC_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R22
    clk_en_i && wr_en && ph_addr == SRCMASK_ADDR |=> src_mask == ($past(hwdata_i) & SRCMASK_WMASK))
    else $error("source mask write wrong");

  // Output mask keeps only its defined fields
  AST_OUT_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R22
    clk_en_i && wr_en && ph_addr == OUTMASK_ADDR |=> out_mask == ($past(hwdata_i) & OUTMASK_WMASK))
    else $error("output mask write wrong");

  // Write-only trigger location reads as zero
  AST_UNMAPPED_READ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R22
    clk_en_i && rd_en && haddr_i[15:0] == SWTRIG_ADDR |=> hrdata_o == 32'h00000000)
    else $error("write-only location read nonzero");

  // Disabled external input never triggers on its own
  AST_EXT_MASKED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // R11
    clk_en_i && !src_mask[EXT_EN_BIT] && !sw_trig && local_over == 8'h00 |=> !acq_trig)
    else $error("masked external trigger accepted");

  // Low clock enable freezes state
  AST_FREEZE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !clk_en_i |=> $stable(src_mask) && $stable(lock_flag) && $stable(acq_trig))
    else $error("state moved while frozen");

  // Bus answer is always ready and OKAY
  AST_BUS_OKAY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    hreadyout_o && !hresp_o)
    else $error("bus response not okay");

endmodule : trigger_acquisition_status

// >>> trigger_acquisition_status_tb_top.sv
`timescale 1ns/1ps
module trigger_acquisition_status_tb_top;
  import trig_acq_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  typedef struct {logic [15:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
  logic ref_clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic ext = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [6:0] st = 7'h20; // sync, lock, bypass, ext clock, full, ready, run
  logic [7:0] ch = 8'h00;
  logic [15:0] pin = 16'h0000;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic acq_trigger_o;
  logic trigger_output_pin_o;
  logic [33:0] post_samples_o;
  logic [15:0] panel_out_o;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_acq = 0;
  int n_out = 0;
  logic [6:0] pats [4] = '{7'h20, 7'h6a, 7'h35, 7'h7f};
  // Reset values first, then masked writes and an unmapped place
  row_t rows [9] = '{
    '{SRCMASK_ADDR, 1'h0, 32'h0, 32'h0}, '{OUTMASK_ADDR, 1'h0, 32'h0, 32'h0},
    '{POST_ADDR, 1'h0, 32'h0, 32'h0}, '{SRCMASK_ADDR, 1'h1, 32'hffffffff, 32'hc70000ff},
    '{OUTMASK_ADDR, 1'h1, 32'hffffffff, 32'hc00000ff},
    '{POST_ADDR, 1'h1, 32'h12345678, 32'h12345678}, '{16'h8120, 1'h1, 32'hffffffff, 32'h0},
    '{SRCMASK_ADDR, 1'h1, 32'h0, 32'h0}, '{OUTMASK_ADDR, 1'h1, 32'h0, 32'h0}};

  trigger_acquisition_status trigger_acquisition_status_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'h1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sync_ok_i(st[6]), .pll_lock_i(st[5]),
    .pll_bypass_i(st[4]), .clk_ext_i(st[3]), .buffer_full_i(st[2]),
    .event_ready_i(st[1]), .run_i(st[0]), .external_trigger_input_i(ext),
    .ch_over_thr_i(ch), .acq_trigger_o(acq_trigger_o),
    .trigger_output_pin_o(trigger_output_pin_o), .post_samples_o(post_samples_o),
    .panel_in_i(pin), .panel_out_o(panel_out_o));

  // ****************************************
  // Clock, pulse counters and hang guard
  // ****************************************
  // Free running board clock
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Counting pulses lets a doubled or lost trigger show up
  always @(posedge ref_clk_i) begin
    cycles++;
    if (acq_trigger_o === 1'h1) n_acq++;
    if (trigger_output_pin_o === 1'h1) n_out++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    $display("Checks %0d, errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // One single transfer; entered and left just after a rising edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {16'h0000, a};
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'h1) @(posedge ref_clk_i);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'h1) @(posedge ref_clk_i);
    rd = hrdata_o;
  endtask : xfer

  // One-cycle trigger stimulus, then count what came out
  task automatic fire(input logic sw, input logic [7:0] c, input logic x,
                      input int ea, input int eo);
    int a0;
    int o0;
    a0 = n_acq;
    o0 = n_out;
    if (sw) xfer(1'h1, SWTRIG_ADDR, 32'h0);
    ch <= c;
    ext <= x;
    @(posedge ref_clk_i);
    ch <= 8'h00;
    ext <= 1'h0;
    repeat (8) @(posedge ref_clk_i);
    chk(n_acq - a0, ea, "acquisition triggers");
    chk(n_out - o0, eo, "output triggers");
  endtask : fire

  task automatic masks(input logic [31:0] s, input logic [31:0] o);
    xfer(1'h1, SRCMASK_ADDR, s);
    xfer(1'h1, OUTMASK_ADDR, o);
  endtask : masks

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    chk(post_samples_o, FIXED_PIPELINE_DELAY, "post after reset");
    chk({hresp_o, hreadyout_o}, 34'h1, "bus response");
    foreach (rows[i]) begin
      if (rows[i].w) xfer(1'h1, rows[i].a, rows[i].d);
      xfer(1'h0, rows[i].a, 32'h0);
      chk(rd, rows[i].e, "register readback");
    end
    foreach (pats[i]) begin
      st <= pats[i];
      repeat (4) @(posedge ref_clk_i);
      xfer(1'h0, STATUS_ADDR, 32'h0);
      chk(rd, {pats[i], 2'h0}, "status");
    end
    // Short lock loss must stay visible until the status is read
    st[5] <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
    st[5] <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    xfer(1'h0, STATUS_ADDR, 32'h0);
    chk(rd, 32'h17c, "lock flag held");
    xfer(1'h0, STATUS_ADDR, 32'h0);
    chk(rd, 32'h1fc, "lock flag restored");
    pin <= 16'ha5c3;
    repeat (3) @(posedge ref_clk_i);
    xfer(1'h0, PANEL_ADDR, 32'h0);
    chk(rd, 32'h0000a5c3, "panel levels");
    xfer(1'h1, PANEL_ADDR, 32'h00003c5a);
    repeat (2) @(posedge ref_clk_i);
    chk(panel_out_o, 16'h3c5a, "panel outputs");
    xfer(1'h1, POST_ADDR, 32'h3fffffff);
    repeat (2) @(posedge ref_clk_i);
    chk(post_samples_o, 34'h0fffffffc + FIXED_PIPELINE_DELAY, "post samples");
    masks(32'h80000000, 32'h0);
    fire(1'h1, 8'h00, 1'h0, 1, 0);
    masks(32'h0, 32'h80000000);
    fire(1'h1, 8'h00, 1'h0, 0, 1);
    masks(32'h40000000, 32'h40000000);
    fire(1'h0, 8'h00, 1'h1, 1, 1);
    fire(1'h1, 8'h00, 1'h0, 0, 0);
    masks(32'h0100000f, 32'h00000010);
    fire(1'h0, 8'h01, 1'h0, 0, 0);
    fire(1'h0, 8'h03, 1'h0, 1, 0);
    fire(1'h0, 8'h11, 1'h0, 0, 1);
    masks(32'h00000080, 32'h0);
    fire(1'h0, 8'h80, 1'h0, 1, 0);
    // Stopped board: every source at once must be ignored
    st[0] <= 1'h0;
    repeat (4) @(posedge ref_clk_i);
    masks(32'hc00000ff, 32'h0);
    fire(1'h1, 8'hff, 1'h1, 0, 0);
    final_report();
  end
endmodule : trigger_acquisition_status_tb_top
